// ==== rtl/est_cfg.svh ====
/*
 * Constants of the eight/sixteen bit timer: register indexes, field
 * positions and reset values.
 * Assumes it is included by its bare name from the timer sources.
 */
`ifndef EST_CFG_SVH
`define EST_CFG_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define EST_IDX_CNT_LOW 12'h59C
`define EST_IDX_PERIOD_HIGH 12'h59D
`define EST_IDX_CTRL_A 12'h59E
`define EST_IDX_CTRL_B 12'h59F
`define EST_IDX_IRQ 12'h5A0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EST_CTRL_A_OUT_BIT 5
`define EST_IRQ_FLAG_BIT 0
`define EST_IRQ_EN_BIT 1
`define EST_IRQ_ROUTE_BIT 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EST_RST_BYTE 8'h00
`define EST_RST_PRE 16'h0000
`define EST_RST_POST 4'h0

`endif

// ==== rtl/est_pkg.sv ====
/*
 * Types of the eight/sixteen bit timer: control register layouts and
 * the clock source encoding.
 * Assumes est_cfg.svh supplies the numeric constants.
 */
`default_nettype none

package est_pkg;

	// Clock sources, in select-field order
	typedef enum logic [2:0] {
		EST_SRC_PIN,
		EST_SRC_PIN_INV,
		EST_SRC_INSTR,
		EST_SRC_HF_OSC,
		EST_SRC_LF_OSC,
		EST_SRC_MF500_OSC,
		EST_SRC_SEC_OSC,
		EST_SRC_LOGIC_CELL
	} est_clk_src_t;

	// First control register
	typedef struct packed {
		logic module_on_bit;
		logic unused;
		logic out_status_bit;
		logic wide_mode_sel;
		logic [3:0] postscale_sel;
	} est_ctrl_a_t;

	// Second control register
	typedef struct packed {
		est_clk_src_t clk_src_sel;
		logic async_sel;
		logic [3:0] prescale_sel;
	} est_ctrl_b_t;

endpackage : est_pkg

`default_nettype wire

// ==== rtl/est_edge_sync.sv ====
/*
 * Two-stage synchroniser with rising edge detect for the selected
 * timer clock source.
 * Assumes src_i is a level that may change at any time.
 */
`timescale 1ns/1ns
`default_nettype none

module est_edge_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic src_i,
	output logic rise_o
);

	logic meta;
	logic stable;
	logic prev;

	// Only the second stage reads the first one
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta <= 1'b0;
			stable <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= src_i;
			stable <= meta;
			prev <= stable;
		end
	end

	// Rising edge of the synchronised level
	assign rise_o = stable & ~prev;

endmodule : est_edge_sync

`default_nettype wire

// ==== rtl/est_timer.sv ====
/*
 * Eight/sixteen bit timer with prescaler, postscaler, toggling output,
 * interrupt flag and classic Wishbone register access.
 * Assumes all inputs are synchronous to clk_i; oscillator inputs are
 * levels far slower than clk_i, instr_tick_i is a one-cycle pulse.
 */
// Added by the designer: the Wishbone register port and the placing of the registers.
// Behaviour
// - One control bit picks 8-bit or 16-bit counting.
// - Counter steps on each rising edge of the prescaled source.
// - 8-bit mode keeps a shadow period and compares it with count.
// - On match the count clears and the shadow reloads from period.
// - 16-bit mode: reading the low byte latches the high byte.
// - 16-bit mode: high byte writes buffered until the low byte write.
// - 16-bit count wraps from FFFF to 0000, runs freely, no reload while on.
// - Clock source comes from a select field in control register b.
// - Sync mode aligns to instruction clock and halts in sleep.
// - Async mode counts on raw edges and keeps counting in sleep.
// - Prescaler offers sixteen ratios from 1:1 to 1:32768.
// - Prescaler hidden; cleared by low byte or control writes, reset.
// - Postscaler divides events by one of sixteen ratios up to 1:16.
// - Postscaler hidden; cleared by low byte or control writes, reset.
// - Output toggles on each postscaled match or rollover.
// - 8-bit mode with zero period holds the output high.
// - Output drives a routed pin and a read-only status bit.
// - Flag sets when the output toggles; enable raises a request.
// - Postscale N sets the flag every N+1 events.
// - Async counting in sleep wakes the device if enabled.
// - Source codes: pin, inverted pin, instr, hf, lf, 500k, sec, cell.
// - Prescale code k divides by two to the power k.
// - Postscale code k divides by k plus one.
// - The timer runs only while the module-enable bit is set.
`timescale 1ns/1ns
`default_nettype none
`include "est_cfg.svh"

module est_timer #(
	parameter int PRE_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [13:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Clock sources and sleep state
	input wire logic ext_clk_pin_i,
	input wire logic instr_tick_i,
	input wire logic hf_osc_i,
	input wire logic lf_osc_i,
	input wire logic mf500_osc_i,
	input wire logic sec_osc_i,
	input wire logic logic_cell_i,
	input wire logic sleep_i,
	// Results
	output logic timer_out_o,
	output logic pin_o,
	output logic irq_o,
	output logic wake_o
);

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	est_pkg::est_ctrl_a_t ctrl_reg_a;
	est_pkg::est_ctrl_b_t ctrl_reg_b;
	logic [7:0] count_low_byte;
	logic [7:0] count_high;
	logic [7:0] period_high_byte;
	logic [7:0] period_shadow;
	logic [PRE_W-1:0] pre_cnt;
	logic [3:0] post_cnt;
	logic timer_out;
	logic timer_irq_flag;
	logic timer_irq_enable;
	logic pin_out_route_sel;
	logic edge_pending;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Prescaler terminal count for ratio 2^k
	function automatic logic est_pre_hit(input logic [PRE_W-1:0] cnt,
		input logic [3:0] k);
		logic [PRE_W-1:0] mask;
		mask = PRE_W'((32'h1 << k) - 32'h1);
		return (cnt & mask) == mask;
	endfunction : est_pre_hit

	// Register select for a given index
	function automatic logic est_hit(input logic [13:0] adr,
		input logic [11:0] idx);
		return adr[13:2] == idx;
	endfunction : est_hit

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic bus_req;
	logic wr_lane;
	logic wr_low;
	logic wr_high;
	logic wr_ctrl_a;
	logic wr_ctrl_b;
	logic wr_irq;
	logic rd_low;
	logic scaler_clear;
	logic wr_load;

	// Strobes fire once, in the cycle before ack rises
	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign wr_lane = bus_req & we_i & sel_i[0];
	assign wr_low = wr_lane & est_hit(adr_i, `EST_IDX_CNT_LOW);
	assign wr_high = wr_lane & est_hit(adr_i, `EST_IDX_PERIOD_HIGH);
	assign wr_ctrl_a = wr_lane & est_hit(adr_i, `EST_IDX_CTRL_A);
	assign wr_ctrl_b = wr_lane & est_hit(adr_i, `EST_IDX_CTRL_B);
	assign wr_irq = wr_lane & est_hit(adr_i, `EST_IDX_IRQ);
	assign rd_low = bus_req & ~we_i & est_hit(adr_i, `EST_IDX_CNT_LOW);
	assign scaler_clear = wr_low | wr_ctrl_a | wr_ctrl_b;
	// A running 16-bit count is free running, so its load is refused
	assign wr_load = wr_low & ~(ctrl_reg_a.wide_mode_sel & ctrl_reg_a.module_on_bit);

	// ----------------------------------------------------------------
	// Clock source selection and synchronisation
	// ----------------------------------------------------------------
	logic src_level;
	logic src_rise;

	// Source mux; the instruction tick is itself a pulse train
	always_comb
	begin
		case (ctrl_reg_b.clk_src_sel)
			est_pkg::EST_SRC_PIN: src_level = ext_clk_pin_i;
			est_pkg::EST_SRC_PIN_INV: src_level = ~ext_clk_pin_i;
			est_pkg::EST_SRC_INSTR: src_level = instr_tick_i;
			est_pkg::EST_SRC_HF_OSC: src_level = hf_osc_i;
			est_pkg::EST_SRC_LF_OSC: src_level = lf_osc_i;
			est_pkg::EST_SRC_MF500_OSC: src_level = mf500_osc_i;
			est_pkg::EST_SRC_SEC_OSC: src_level = sec_osc_i;
			est_pkg::EST_SRC_LOGIC_CELL: src_level = logic_cell_i;
			default: src_level = 1'b0;
		endcase
	end

	est_edge_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_i(src_level),
		.rise_o(src_rise)
	);

	// ----------------------------------------------------------------
	// Run conditions
	// ----------------------------------------------------------------
	logic running;
	logic pre_tick;
	logic count_tick;
	logic pre_ok;

	// Sync mode stops in sleep; async keeps going
	assign running = ctrl_reg_a.module_on_bit
		& (ctrl_reg_b.async_sel | ~sleep_i);
	// Sync mode waits for an instruction tick with an edge pending
	assign pre_tick = running & (ctrl_reg_b.async_sel ? src_rise
		: ((edge_pending | src_rise) & instr_tick_i));
	assign pre_ok = est_pre_hit(pre_cnt, ctrl_reg_b.prescale_sel);
	assign count_tick = pre_tick & pre_ok & ~scaler_clear;

	// Edge caught between instruction ticks in sync mode
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			edge_pending <= 1'b0;
		end
		else if (!running || ctrl_reg_b.async_sel || instr_tick_i)
		begin
			edge_pending <= 1'b0;
		end
		else if (src_rise)
		begin
			edge_pending <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i || scaler_clear)
		begin
			pre_cnt <= PRE_W'(`EST_RST_PRE);
		end
		else if (pre_tick)
		begin
			pre_cnt <= pre_ok ? PRE_W'(0) : pre_cnt + PRE_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	logic match8;
	logic roll16;
	logic count_event;

	assign match8 = count_low_byte == period_shadow;
	assign roll16 = {count_high, count_low_byte} == 16'hFFFF;
	assign count_event = count_tick & (ctrl_reg_a.wide_mode_sel
		? roll16 : (match8 && period_shadow != 8'h00));

	// Low byte: software load wins over a count step
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_low_byte <= `EST_RST_BYTE;
		end
		else if (wr_load)
		begin
			count_low_byte <= dat_i[7:0];
		end
		else if (count_tick)
		begin
			if (!ctrl_reg_a.wide_mode_sel && match8)
			begin
				count_low_byte <= 8'h00;
			end
			else
			begin
				count_low_byte <= count_low_byte + 8'h01;
			end
		end
	end

	// High count byte, used in 16-bit mode only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_high <= `EST_RST_BYTE;
		end
		else if (wr_load && ctrl_reg_a.wide_mode_sel)
		begin
			count_high <= period_high_byte;
		end
		else if (count_tick && ctrl_reg_a.wide_mode_sel
			&& count_low_byte == 8'hFF)
		begin
			count_high <= count_high + 8'h01;
		end
	end

	// Period register doubles as the 16-bit read/write buffer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			period_high_byte <= `EST_RST_BYTE;
		end
		else if (wr_high)
		begin
			period_high_byte <= dat_i[7:0];
		end
		else if (rd_low && ctrl_reg_a.wide_mode_sel)
		begin
			period_high_byte <= count_high;
		end
	end

	// Shadow period follows the register only at a match or while idle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			period_shadow <= `EST_RST_BYTE;
		end
		else if (!ctrl_reg_a.module_on_bit
			|| (count_tick && !ctrl_reg_a.wide_mode_sel && match8))
		begin
			period_shadow <= period_high_byte;
		end
	end

	// ----------------------------------------------------------------
	// Postscaler and output
	// ----------------------------------------------------------------
	logic post_hit;

	assign post_hit = count_event && post_cnt == ctrl_reg_a.postscale_sel;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || scaler_clear)
		begin
			post_cnt <= `EST_RST_POST;
		end
		else if (count_event)
		begin
			post_cnt <= post_hit ? 4'h0 : post_cnt + 4'h1;
		end
	end

	// Zero period in 8-bit mode pins the output high
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timer_out <= 1'b0;
		end
		else if (running && !ctrl_reg_a.wide_mode_sel
			&& period_high_byte == 8'h00)
		begin
			timer_out <= 1'b1;
		end
		else if (post_hit)
		begin
			timer_out <= ~timer_out;
		end
	end

	// ----------------------------------------------------------------
	// Control and interrupt registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_reg_a <= '0;
			ctrl_reg_b <= '0;
		end
		else
		begin
			if (wr_ctrl_a)
			begin
				ctrl_reg_a <= est_pkg::est_ctrl_a_t'(dat_i[7:0]);
			end
			if (wr_ctrl_b)
			begin
				ctrl_reg_b <= est_pkg::est_ctrl_b_t'(dat_i[7:0]);
			end
			// Status bit is hardware owned
			ctrl_reg_a.unused <= 1'b0;
			ctrl_reg_a.out_status_bit <= timer_out;
		end
	end

	// Flag: write one to clear, a toggle in the same cycle wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timer_irq_flag <= 1'b0;
			timer_irq_enable <= 1'b0;
			pin_out_route_sel <= 1'b0;
		end
		else
		begin
			if (post_hit)
			begin
				timer_irq_flag <= 1'b1;
			end
			else if (wr_irq && dat_i[`EST_IRQ_FLAG_BIT])
			begin
				timer_irq_flag <= 1'b0;
			end
			if (wr_irq)
			begin
				timer_irq_enable <= dat_i[`EST_IRQ_EN_BIT];
				pin_out_route_sel <= dat_i[`EST_IRQ_ROUTE_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timer_out_o <= 1'b0;
			pin_o <= 1'b0;
			irq_o <= 1'b0;
			wake_o <= 1'b0;
		end
		else
		begin
			timer_out_o <= timer_out;
			pin_o <= pin_out_route_sel & timer_out;
			irq_o <= timer_irq_flag & timer_irq_enable;
			// Only async mode can run while asleep
			wake_o <= timer_irq_flag & timer_irq_enable & sleep_i
				& ctrl_reg_b.async_sel;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone answer
	// ----------------------------------------------------------------
	logic [7:0] rd_byte;

	// Unmapped addresses read zero and accept writes silently
	always_comb
	begin
		rd_byte = 8'h00;
		if (est_hit(adr_i, `EST_IDX_CNT_LOW))
		begin
			rd_byte = count_low_byte;
		end
		else if (est_hit(adr_i, `EST_IDX_PERIOD_HIGH))
		begin
			rd_byte = period_high_byte;
		end
		else if (est_hit(adr_i, `EST_IDX_CTRL_A))
		begin
			rd_byte = ctrl_reg_a;
		end
		else if (est_hit(adr_i, `EST_IDX_CTRL_B))
		begin
			rd_byte = ctrl_reg_b;
		end
		else if (est_hit(adr_i, `EST_IDX_IRQ))
		begin
			rd_byte = {5'h00, pin_out_route_sel, timer_irq_enable,
				timer_irq_flag};
		end
	end

	// One wait state: ack one cycle after the request, then drop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= bus_req;
			if (bus_req && !we_i)
			begin
				dat_o <= {24'h00_0000, rd_byte};
			end
		end
	end

endmodule : est_timer

`default_nettype wire

// ==== tb/est_timer_asserts.sv ====
/*
 * Checker for the eight/sixteen bit timer, bound to est_timer.
 * Assumes a Wishbone master that drops stb between requests.
 */
`timescale 1ns/1ns
`default_nettype none
`include "est_cfg.svh"

module est_timer_asserts #(
	parameter int PRE_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [13:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic sleep_i,
	input wire logic timer_out_o,
	input wire logic pin_o,
	input wire logic irq_o,
	input wire logic wake_o
);
	// ----------------------------------------------------------------
	// Mirror of enable and route bits
	// ----------------------------------------------------------------
	logic en_q;
	logic route_q;

	// Copied from bus writes, since the checker cannot see the registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			en_q <= 1'h0;
			route_q <= 1'h0;
		end
		else if (cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i[13:2] == `EST_IDX_IRQ)
		begin
			en_q <= dat_i[`EST_IRQ_EN_BIT];
			route_q <= dat_i[`EST_IRQ_ROUTE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_answer;
		ack_o ##1 !ack_o;
	endsequence

	AST_ACK_ONE: assert property (s_take |=> s_answer) else $error("ack late or long");
	AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
	AST_DAT_TOP: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
		else $error("read data high bits set");
	AST_DAT_HOLD: assert property (!$past(cyc_i && stb_i && !ack_o && !we_i) |-> $stable(dat_o))
		else $error("read data moved without a read");
	AST_IRQ_TOGGLE: assert property (en_q && $fell(timer_out_o) |=> irq_o)
		else $error("toggle raised no request");
	AST_IRQ_OFF: assert property (!en_q |=> !irq_o) else $error("request while disabled");
	AST_WAKE_IRQ: assert property (wake_o |-> irq_o) else $error("wake without request");
	AST_WAKE_SLEEP: assert property (wake_o |-> $past(sleep_i)) else $error("wake while awake");
	AST_PIN_ROUTE: assert property (pin_o |-> route_q || $past(route_q))
		else $error("pin driven without route");
	AST_RESET: assert property (disable iff (1'h0) rst_i |=> !ack_o && !irq_o && !wake_o && !pin_o
		&& !timer_out_o) else $error("outputs not cleared by reset");
endmodule : est_timer_asserts

bind est_timer est_timer_asserts #(.PRE_W(PRE_W)) u_asserts (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i), .timer_out_o(timer_out_o), .pin_o(pin_o),
	.irq_o(irq_o), .wake_o(wake_o));

`default_nettype wire

// ==== tb/est_timer_tb_top.sv ====
/*
 * Self-checking bench for the eight/sixteen bit timer.
 * Assumes est_timer answers Wishbone requests and the checker is bound.
 */
`timescale 1ns/1ns
`default_nettype none
`include "est_cfg.svh"

`define CHK(nm, exp, got) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			$display("unexpected %s expected %h seen %h", nm, exp, got); \
			bad_count++; \
		end \
	end

module est_timer_tb_top;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc_i = 1'h0;
	logic stb_i = 1'h0;
	logic we_i = 1'h0;
	logic [13:0] adr_i = 14'h0000;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic ack_o, timer_out_o, pin_o, irq_o, wake_o;
	logic [7:0] srcv = 8'h00; // One level per source code, bit 1 unused
	logic sleep_i = 1'h0;
	logic tick = 1'h0;
	logic tick_run = 1'h0;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	est_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.ext_clk_pin_i(srcv[0]), .instr_tick_i(srcv[2] | tick), .hf_osc_i(srcv[3]),
		.lf_osc_i(srcv[4]), .mf500_osc_i(srcv[5]), .sec_osc_i(srcv[6]),
		.logic_cell_i(srcv[7]), .sleep_i(sleep_i), .timer_out_o(timer_out_o),
		.pin_o(pin_o), .irq_o(irq_o), .wake_o(wake_o));

	// Clock, instruction tick every other cycle, hang guard
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		tick <= tick_run & ~tick;
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Bus, source and end-of-test tasks
	// ----------------------------------------------------------------
	// Classic cycle; hangs are cut by the cycle guard, not here
	task wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= {idx, 2'h0};
		sel_i <= 4'hF;
		dat_i <= {24'h000000, d};
		@(posedge clk_i);
		while (ack_o !== 1'h1)
			@(posedge clk_i);
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i <= 1'h0;
	endtask : wb

	task wr(input logic [11:0] idx, input logic [7:0] d);
		wb(1'h1, idx, d);
	endtask : wr

	task rchk(input logic [11:0] idx, input logic [7:0] exp);
		wb(1'h0, idx, 8'h00);
		`CHK($sformatf("reg %h", idx), {24'h000000, exp}, rd)
	endtask : rchk

	// One-cycle high pulses, slow enough for the synchroniser
	task pulse(input int i, input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			srcv[i] <= 1'h1;
			@(posedge clk_i);
			srcv[i] <= 1'h0;
			repeat (6) @(posedge clk_i);
		end
		repeat (8) @(posedge clk_i);
	endtask : pulse

	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		for (int i = 0; i < 5; i++)
			rchk(12'h59C + i[11:0], 8'h00);
		wr(12'h100, 8'h5A);
		rchk(12'h100, 8'h00);
		// Each source, async, no prescale; clear count after select
		wr(`EST_IDX_PERIOD_HIGH, 8'hFF);
		wr(`EST_IDX_CTRL_A, 8'h80);
		for (int c = 0; c < 8; c++)
		begin
			wr(`EST_IDX_CTRL_B, {c[2:0], 5'h10});
			wr(`EST_IDX_CNT_LOW, 8'h00);
			pulse((c == 1) ? 0 : c, 3);
			rchk(`EST_IDX_CNT_LOW, 8'h03);
		end
		// Prescale 1:4 and its clearing
		wr(`EST_IDX_CTRL_B, 8'h72);
		wr(`EST_IDX_CNT_LOW, 8'h00);
		pulse(3, 9);
		rchk(`EST_IDX_CNT_LOW, 8'h02);
		wr(`EST_IDX_CNT_LOW, 8'h00);
		pulse(3, 3);
		wr(`EST_IDX_CTRL_A, 8'h80);
		pulse(3, 3);
		rchk(`EST_IDX_CNT_LOW, 8'h00);
		pulse(3, 1);
		rchk(`EST_IDX_CNT_LOW, 8'h01);
		// Hold while off, then period 3 with postscale 1:2
		wr(`EST_IDX_CTRL_B, 8'h70);
		wr(`EST_IDX_CTRL_A, 8'h00);
		wr(`EST_IDX_CNT_LOW, 8'h00);
		pulse(3, 5);
		rchk(`EST_IDX_CNT_LOW, 8'h00);
		wr(`EST_IDX_PERIOD_HIGH, 8'h03);
		wr(`EST_IDX_IRQ, 8'h06);
		wr(`EST_IDX_CTRL_A, 8'h81);
		wr(`EST_IDX_CNT_LOW, 8'h00);
		pulse(3, 4);
		rchk(`EST_IDX_CNT_LOW, 8'h00);
		rchk(`EST_IDX_IRQ, 8'h06);
		pulse(3, 4);
		rchk(`EST_IDX_CTRL_A, 8'hA1);
		rchk(`EST_IDX_IRQ, 8'h07);
		`CHK("irq", 1'h1, irq_o)
		`CHK("pin", 1'h1, pin_o)
		wr(`EST_IDX_IRQ, 8'h05);
		rchk(`EST_IDX_IRQ, 8'h04);
		// Async counting in sleep wakes the device
		sleep_i <= 1'h1;
		wr(`EST_IDX_IRQ, 8'h02);
		pulse(3, 8);
		`CHK("wake", 1'h1, wake_o)
		`CHK("out", 1'h0, timer_out_o)
		`CHK("pin", 1'h0, pin_o)
		sleep_i <= 1'h0;
		// Zero period holds the output high with no flag
		wr(`EST_IDX_IRQ, 8'h03);
		wr(`EST_IDX_CTRL_A, 8'h00);
		wr(`EST_IDX_PERIOD_HIGH, 8'h00);
		wr(`EST_IDX_CTRL_A, 8'h80);
		pulse(3, 3);
		`CHK("out", 1'h1, timer_out_o)
		rchk(`EST_IDX_IRQ, 8'h02);
		// Sixteen bits: buffered load, rollover, latched high byte
		wr(`EST_IDX_CTRL_A, 8'h10);
		wr(`EST_IDX_PERIOD_HIGH, 8'hFF);
		wr(`EST_IDX_CNT_LOW, 8'hFE);
		wr(`EST_IDX_CTRL_A, 8'h90);
		pulse(3, 3);
		rchk(`EST_IDX_CNT_LOW, 8'h01);
		rchk(`EST_IDX_PERIOD_HIGH, 8'h00);
		// Synchronous mode stops in sleep
		tick_run <= 1'h1;
		wr(`EST_IDX_CTRL_B, 8'h60);
		wr(`EST_IDX_CNT_LOW, 8'h00);
		sleep_i <= 1'h1;
		pulse(3, 3);
		rchk(`EST_IDX_CNT_LOW, 8'h01);
		sleep_i <= 1'h0;
		pulse(3, 3);
		rchk(`EST_IDX_CNT_LOW, 8'h04);
		test_done();
	end
endmodule : est_timer_tb_top

`default_nettype wire
